// ===== rtl/dsc_consts.svh
// Register offsets, field positions and reset values of the disc request scheduler
`ifndef DSC_CONSTS_SVH
`define DSC_CONSTS_SVH
`define DSC_OFF_CTRL      8'h00
`define DSC_OFF_FAIR      8'h04
`define DSC_OFF_LOOK      8'h08
`define DSC_OFF_QDEPTH    8'h0c
`define DSC_OFF_USEL      8'h10
`define DSC_OFF_USIZE     8'h14
`define DSC_OFF_UMEDIA_LO 8'h18
`define DSC_OFF_UMEDIA_HI 8'h1c
`define DSC_OFF_UWCONF    8'h20
`define DSC_OFF_USERIAL   8'h24
`define DSC_OFF_STRUCT    8'h28
`define DSC_OFF_STAT_CMD  8'h2c
`define DSC_OFF_STAT_RD   8'h30
`define DSC_OFF_STAT_HIT  8'h34
`define DSC_OFF_STATUS    8'h38
`define DSC_CTRL_STRAT_HI 1
`define DSC_CTRL_STRAT_LO 0
`define DSC_CTRL_CACHE    2
`define DSC_CTRL_PANEL_HI 4
`define DSC_CTRL_PANEL_LO 3
`define DSC_RST_STRAT     2'h0
`define DSC_RST_CACHE     1'h1
`define DSC_RST_PANEL     2'h0
`define DSC_RST_FAIR      8'h19
`define DSC_RST_LOOK      8'h01
`define DSC_RST_QDEPTH    4'h8
`define DSC_RST_WCONF     2'h2
`define DSC_STAT_PERIOD   10'h3e8
`define DSC_STRUCT_BLKS   8'h03
`endif

// ===== rtl/dsc_pkg.sv
// Types shared by the disc request scheduler
package dsc_pkg;
	typedef enum logic [1:0] {
		DSC_OPT_NONE    = 2'h0,
		DSC_OPT_NEAREST = 2'h1,
		DSC_OPT_ELEV    = 2'h2,
		DSC_OPT_FORWARD = 2'h3
	} dsc_strat_t;
	typedef enum logic [1:0] {
		DSC_PANEL_NONE    = 2'h0,
		DSC_PANEL_PASSIVE = 2'h1,
		DSC_PANEL_ACTIVE  = 2'h2
	} dsc_panel_t;
	typedef enum logic [2:0] {
		DSC_OP_READ    = 3'h0,
		DSC_OP_WRITE   = 3'h1,
		DSC_OP_HDRFMT  = 3'h2,
		DSC_OP_PATTERN = 3'h3,
		DSC_OP_STRUCT  = 3'h4,
		DSC_OP_RCTCLR  = 3'h5,
		DSC_OP_STATS   = 3'h6
	} dsc_op_t;
	typedef enum logic [2:0] {
		DSC_ST_IDLE = 3'h0,
		DSC_ST_HDR  = 3'h1,
		DSC_ST_PAT  = 3'h3,
		DSC_ST_STA  = 3'h2,
		DSC_ST_STB  = 3'h6,
		DSC_ST_RCT  = 3'h7,
		DSC_ST_REQ  = 3'h4,
		DSC_ST_STW  = 3'h5
	} dsc_state_t;
	typedef enum logic [1:0] {
		DSC_SCMD_NONE   = 2'h0,
		DSC_SCMD_FORMAT = 2'h1,
		DSC_SCMD_WRITE  = 2'h2,
		DSC_SCMD_UPDATE = 2'h3
	} dsc_scmd_t;
	localparam logic [1:0] DSC_WC_CACHE = 2'h1;
endpackage

// ===== rtl/dsc_sched.sv
// Disc request queue, seek scheduler, lookahead cache policy and structure sequencer
`include "dsc_consts.svh"
module dsc_sched (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic [7:0]         addr_i,
	input  wire logic [31:0]        wdata_i,
	input  wire logic               wr_i,
	input  wire logic               rd_i,
	output logic      [31:0]        rdata_o,
	input  wire logic               req_valid_i,
	output logic                    req_ready_o,
	input  wire logic [1:0]         req_unit_i,
	input  wire logic               req_write_i,
	input  wire logic [15:0]        req_cyl_i,
	input  wire logic [31:0]        req_lba_i,
	input  wire logic [7:0]         req_len_i,
	output logic                    done_o,
	output logic                    done_hit_o,
	output logic                    done_err_o,
	output logic                    dsk_start_o,
	output dsc_pkg::dsc_op_t        dsk_op_o,
	output logic      [1:0]         dsk_unit_o,
	output logic      [15:0]        dsk_cyl_o,
	output logic      [31:0]        dsk_lba_o,
	output logic      [7:0]         dsk_len_o,
	input  wire logic               dsk_done_i,
	input  wire logic [1:0]         info_unit_i,
	output logic      [39:0]        info_media_o,
	output logic      [31:0]        info_serial_o,
	output logic      [3:0]         units_o,
	output dsc_pkg::dsc_panel_t     panel_o
);
	import dsc_pkg::*;

	dsc_strat_t  strat_q;
	dsc_panel_t  panel_q;
	dsc_state_t  st_q, st_d;
	dsc_scmd_t   scmd_q;
	logic        cache_q, rct_q, up_q, la_v_q, stw_q, cur_ntf_q;
	logic [7:0]  fair_init_q, look_q, q_len [8], q_fair [8], la_cnt_q, la_pcnt_q;
	logic [3:0]  qdepth_q, qcnt;
	logic [1:0]  usel_q, wconf_q [4], q_unit [8], la_unit_q, la_punit_q;
	logic [31:0] usize_q [4], serial_q [4], q_lba [8], la_base_q, la_pbase_q;
	logic [31:0] cnt_cmd_q, cnt_rd_q, cnt_hit_q, rdata_q;
	logic [39:0] media_q [4];
	logic [15:0] head_q, q_cyl [8];
	logic [9:0]  acc_q;
	logic [7:0]  q_v, q_wr, q_ntf;
	logic [2:0]  sel, free;
	logic [16:0] sel_cost;
	logic        zero_hit, acc, unit_ok, hit, cached, go_req, start;
	logic [7:0]  eff_len;

	// Cost of a candidate cylinder; bit 16 marks the far side of a sweep
	function automatic logic [16:0] cost_f(input dsc_strat_t s, input logic [15:0] cyl,
		input logic [15:0] head, input logic up);
		logic [15:0] d;
		d = (cyl >= head) ? cyl - head : head - cyl;
		case (s)
			DSC_OPT_NEAREST: cost_f = {1'b0, d};
			DSC_OPT_ELEV:    cost_f = {!(up ? cyl >= head : cyl <= head), d};
			DSC_OPT_FORWARD: cost_f = (cyl >= head) ? {1'b0, d} : {1'b1, cyl};
			default:         cost_f = 17'h00000;
		endcase
	endfunction

	// Pick: a spent fairness count wins unless the strategy is none, else least cost, ties to lowest slot
	always_comb begin
		logic [16:0] c;
		c = 17'h00000;
		sel = 3'h0;
		sel_cost = 17'h1ffff;
		zero_hit = 1'b0;
		for (int i = 0; i < 8; i++) begin
			c = cost_f(strat_q, q_cyl[i], head_q, up_q);
			if (q_v[i] && !zero_hit) begin
				if (strat_q != DSC_OPT_NONE && q_fair[i] == 8'h00) begin
					sel = i[2:0];
					zero_hit = 1'b1;
				end else if (c < sel_cost || sel_cost == 17'h1ffff) begin
					sel = i[2:0];
					sel_cost = c;
				end
			end
		end
	end

	// Free slot and occupancy
	always_comb begin
		free = 3'h0;
		qcnt = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			if (!q_v[i])
				free = i[2:0];
			qcnt = qcnt + {3'h0, q_v[i]};
		end
	end

	// Acceptance and its immediate outcomes
	assign unit_ok = usize_q[req_unit_i] != 32'h0;
	assign hit = cache_q && la_v_q && !req_write_i && la_unit_q == req_unit_i
		&& req_lba_i >= la_base_q
		&& ({1'b0, req_lba_i - la_base_q} + {25'h0, req_len_i}) <= {25'h0, la_cnt_q};
	assign cached = cache_q && wconf_q[req_unit_i] == DSC_WC_CACHE;
	// A structure command or a finishing disc op holds the host off so completions never collide
	assign req_ready_o = qcnt < qdepth_q && dsk_done_i == 1'b0
		&& scmd_q == DSC_SCMD_NONE && (st_q == DSC_ST_IDLE || st_q == DSC_ST_REQ
		|| st_q == DSC_ST_STW);
	assign acc = req_valid_i && req_ready_o;
	assign go_req = st_q == DSC_ST_IDLE && st_d == DSC_ST_REQ;
	assign start = st_d != st_q && st_d != DSC_ST_IDLE;
	assign eff_len = (cache_q && !q_wr[sel] && q_len[sel] < look_q) ? look_q : q_len[sel];

	// Request queue; skipped entries age toward forced selection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_v <= 8'h00;
		end else begin
			if (go_req) begin
				q_v[sel] <= 1'b0;
				for (int j = 0; j < 8; j++)
					if (j[2:0] != sel && q_v[j] && strat_q != DSC_OPT_NONE
						&& q_fair[j] != 8'h00)
						q_fair[j] <= q_fair[j] - 8'h01;
			end
			if (acc && unit_ok && !hit) begin
				q_v[free]    <= 1'b1;
				q_wr[free]   <= req_write_i;
				q_ntf[free]  <= !(req_write_i && cached);
				q_unit[free] <= req_unit_i;
				q_cyl[free]  <= req_cyl_i;
				q_lba[free]  <= req_lba_i;
				q_len[free]  <= req_len_i;
				q_fair[free] <= fair_init_q;
			end
		end
	end

	// Sequencer next state
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			DSC_ST_IDLE:
				if (scmd_q == DSC_SCMD_FORMAT)
					st_d = DSC_ST_HDR;
				else if (scmd_q != DSC_SCMD_NONE)
					st_d = DSC_ST_STA;
				else if (stw_q)
					st_d = DSC_ST_STW;
				else if (q_v != 8'h00)
					st_d = DSC_ST_REQ;
			DSC_ST_HDR: if (dsk_done_i) st_d = DSC_ST_PAT;
			DSC_ST_PAT: if (dsk_done_i) st_d = DSC_ST_STA;
			DSC_ST_STA: if (dsk_done_i) st_d = DSC_ST_STB;
			DSC_ST_STB: if (dsk_done_i) st_d = rct_q ? DSC_ST_RCT : DSC_ST_IDLE;
			DSC_ST_RCT: if (dsk_done_i) st_d = DSC_ST_IDLE;
			DSC_ST_REQ: if (dsk_done_i) st_d = DSC_ST_IDLE;
			DSC_ST_STW: if (dsk_done_i) st_d = DSC_ST_IDLE;
		endcase
	end

	// State, structure command and replacement table choice
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= DSC_ST_IDLE;
			scmd_q <= DSC_SCMD_NONE;
			rct_q <= 1'b0;
		end else begin
			st_q <= st_d;
			if (st_q == DSC_ST_IDLE && scmd_q != DSC_SCMD_NONE) begin
				scmd_q <= DSC_SCMD_NONE;
				rct_q <= scmd_q != DSC_SCMD_UPDATE;
			end
			// A new command written in the take cycle is kept, not lost
			if (wr_i && addr_i == `DSC_OFF_STRUCT)
				scmd_q <= dsc_scmd_t'(wdata_i[1:0]);
		end
	end

	// Disc command outputs, loaded with the start pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dsk_start_o <= 1'b0;
			dsk_op_o <= DSC_OP_READ;
			dsk_unit_o <= 2'h0;
			dsk_cyl_o <= 16'h0000;
			dsk_lba_o <= 32'h0;
			dsk_len_o <= 8'h00;
			cur_ntf_q <= 1'b0;
		end else begin
			dsk_start_o <= start;
			if (go_req) begin
				dsk_op_o <= q_wr[sel] ? DSC_OP_WRITE : DSC_OP_READ;
				dsk_unit_o <= q_unit[sel];
				dsk_cyl_o <= q_cyl[sel];
				dsk_lba_o <= q_lba[sel];
				dsk_len_o <= eff_len;
				cur_ntf_q <= q_ntf[sel];
			end else if (start) begin
				unique case (st_d)
					DSC_ST_HDR: dsk_op_o <= DSC_OP_HDRFMT;
					DSC_ST_PAT: dsk_op_o <= DSC_OP_PATTERN;
					DSC_ST_RCT: dsk_op_o <= DSC_OP_RCTCLR;
					DSC_ST_STW: dsk_op_o <= DSC_OP_STATS;
					default:    dsk_op_o <= DSC_OP_STRUCT;
				endcase
				dsk_cyl_o <= 16'h0000;
				// Second structure copy follows the first on track zero
				dsk_lba_o <= st_d == DSC_ST_STB ? {24'h0, `DSC_STRUCT_BLKS} : 32'h0;
				dsk_len_o <= (st_d == DSC_ST_STA || st_d == DSC_ST_STB)
					? `DSC_STRUCT_BLKS : 8'h00;
				cur_ntf_q <= 1'b0;
			end
		end
	end

	// Head position and elevator direction follow each issued request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			head_q <= 16'h0000;
			up_q <= 1'b1;
		end else if (go_req) begin
			head_q <= q_cyl[sel];
			if (strat_q == DSC_OPT_ELEV && sel_cost[16] && !zero_hit)
				up_q <= !up_q;
		end
	end

	// Lookahead range becomes usable only once its read has finished
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			la_v_q <= 1'b0;
			{la_base_q, la_cnt_q, la_unit_q} <= 42'h0;
			{la_pbase_q, la_pcnt_q, la_punit_q} <= 42'h0;
		end else begin
			if (go_req && !q_wr[sel]) begin
				la_pbase_q <= q_lba[sel];
				la_pcnt_q <= eff_len;
				la_punit_q <= q_unit[sel];
				la_v_q <= 1'b0;
			end
			if (st_q == DSC_ST_REQ && dsk_done_i && dsk_op_o == DSC_OP_READ) begin
				la_base_q <= la_pbase_q;
				la_cnt_q <= la_pcnt_q;
				la_unit_q <= la_punit_q;
				la_v_q <= cache_q;
			end
			// Stale data must not satisfy a read after a write or with the cache off
			if ((acc && req_write_i) || !cache_q)
				la_v_q <= 1'b0;
		end
	end

	// Host completion pulses
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{done_o, done_hit_o, done_err_o} <= 3'h0;
		end else begin
			done_o <= (acc && (!unit_ok || hit || (req_write_i && cached)))
				|| (st_q == DSC_ST_REQ && dsk_done_i && cur_ntf_q);
			done_hit_o <= acc && unit_ok && hit;
			done_err_o <= acc && !unit_ok;
		end
	end

	// Statistics and the periodic write request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{cnt_cmd_q, cnt_rd_q, cnt_hit_q} <= 96'h0;
			acc_q <= 10'h000;
			stw_q <= 1'b0;
		end else begin
			if (acc) begin
				cnt_cmd_q <= cnt_cmd_q + 32'h1;
				cnt_rd_q <= cnt_rd_q + {31'h0, !req_write_i};
				cnt_hit_q <= cnt_hit_q + {31'h0, hit && unit_ok};
			end
			if (st_q == DSC_ST_IDLE && st_d == DSC_ST_STW)
				stw_q <= 1'b0;
			if (go_req) begin
				acc_q <= (acc_q == `DSC_STAT_PERIOD - 10'h001) ? 10'h000 : acc_q + 10'h001;
				if (acc_q == `DSC_STAT_PERIOD - 10'h001)
					stw_q <= 1'b1;
			end
		end
	end

	// Register writes; control bits steer the scheduler and cache policy
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strat_q <= dsc_strat_t'(`DSC_RST_STRAT);
			cache_q <= `DSC_RST_CACHE;
			panel_q <= dsc_panel_t'(`DSC_RST_PANEL);
			fair_init_q <= `DSC_RST_FAIR;
			look_q <= `DSC_RST_LOOK;
			qdepth_q <= `DSC_RST_QDEPTH;
			usel_q <= 2'h0;
			for (int u = 0; u < 4; u++) begin
				usize_q[u] <= 32'h0;
				media_q[u] <= 40'h0;
				serial_q[u] <= 32'h0;
				wconf_q[u] <= `DSC_RST_WCONF;
			end
		end else if (wr_i) begin
			case (addr_i)
				`DSC_OFF_CTRL: begin
					strat_q <= dsc_strat_t'(wdata_i[`DSC_CTRL_STRAT_HI:`DSC_CTRL_STRAT_LO]);
					cache_q <= wdata_i[`DSC_CTRL_CACHE];
					// Panel code 3 is not defined and is ignored
					if (wdata_i[`DSC_CTRL_PANEL_HI:`DSC_CTRL_PANEL_LO] != 2'h3)
						panel_q <= dsc_panel_t'(wdata_i[`DSC_CTRL_PANEL_HI:`DSC_CTRL_PANEL_LO]);
				end
				`DSC_OFF_FAIR:      fair_init_q <= wdata_i[7:0];
				`DSC_OFF_LOOK:      look_q <= wdata_i[7:0];
				`DSC_OFF_QDEPTH: begin
					// Depth is clamped to the eight physical slots, never zero
					if (wdata_i[3:0] == 4'h0)
						qdepth_q <= 4'h1;
					else if (wdata_i[3:0] > `DSC_RST_QDEPTH)
						qdepth_q <= `DSC_RST_QDEPTH;
					else
						qdepth_q <= wdata_i[3:0];
				end
				`DSC_OFF_USEL:      usel_q <= wdata_i[1:0];
				`DSC_OFF_USIZE:     usize_q[usel_q] <= wdata_i;
				`DSC_OFF_UMEDIA_LO: media_q[usel_q][31:0] <= wdata_i;
				`DSC_OFF_UMEDIA_HI: media_q[usel_q][39:32] <= wdata_i[7:0];
				`DSC_OFF_UWCONF:    wconf_q[usel_q] <= wdata_i[1:0];
				`DSC_OFF_USERIAL:   serial_q[usel_q] <= wdata_i;
				default: ;
			endcase
		end
	end

	// Register reads, data in the following cycle only
	always_ff @(posedge clk_i) begin
		if (rst_i || !rd_i) begin
			rdata_q <= 32'h0;
		end else begin
			case (addr_i)
				`DSC_OFF_CTRL:      rdata_q <= {27'h0, panel_q, cache_q, strat_q};
				`DSC_OFF_FAIR:      rdata_q <= {24'h0, fair_init_q};
				`DSC_OFF_LOOK:      rdata_q <= {24'h0, look_q};
				`DSC_OFF_QDEPTH:    rdata_q <= {28'h0, qdepth_q};
				`DSC_OFF_USEL:      rdata_q <= {30'h0, usel_q};
				`DSC_OFF_USIZE:     rdata_q <= usize_q[usel_q];
				`DSC_OFF_UMEDIA_LO: rdata_q <= media_q[usel_q][31:0];
				`DSC_OFF_UMEDIA_HI: rdata_q <= {24'h0, media_q[usel_q][39:32]};
				`DSC_OFF_UWCONF:    rdata_q <= {30'h0, wconf_q[usel_q]};
				`DSC_OFF_USERIAL:   rdata_q <= serial_q[usel_q];
				`DSC_OFF_STRUCT:    rdata_q <= {28'h0, st_q, scmd_q != DSC_SCMD_NONE};
				`DSC_OFF_STAT_CMD:  rdata_q <= cnt_cmd_q;
				`DSC_OFF_STAT_RD:   rdata_q <= cnt_rd_q;
				`DSC_OFF_STAT_HIT:  rdata_q <= cnt_hit_q;
				`DSC_OFF_STATUS:    rdata_q <= {24'h0, units_o, qcnt};
				default:            rdata_q <= 32'h0;
			endcase
		end
	end
	assign rdata_o = rdata_q;
	assign panel_o = panel_q;

	// Unit status and online answers for the protocol engine
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			info_media_o <= 40'h0;
			info_serial_o <= 32'h0;
			units_o <= 4'h0;
		end else begin
			info_media_o <= media_q[info_unit_i];
			info_serial_o <= serial_q[info_unit_i];
			for (int u = 0; u < 4; u++)
				units_o[u] <= usize_q[u] != 32'h0;
		end
	end

	forced_pick_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(go_req && strat_q != DSC_OPT_NONE && q_v[0] && q_fair[0] == 8'h00) |-> sel == 3'h0)
		else $error("spent fairness entry not picked");
	first_found_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(go_req && strat_q == DSC_OPT_NONE) |-> (q_v & ((8'h01 << sel) - 8'h01)) == 8'h00)
		else $error("no-optimisation pick is not the first entry");
	fair_age_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(go_req && sel != 3'h0 && q_v[0] && strat_q != DSC_OPT_NONE && q_fair[0] != 8'h00)
		|=> q_fair[0] == $past(q_fair[0]) - 8'h01)
		else $error("skipped entry did not age");
	look_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(go_req && !q_wr[sel]) |=> dsk_start_o && dsk_len_o ==
		(($past(cache_q) && $past(q_len[sel]) < $past(look_q)) ? $past(look_q) : $past(q_len[sel])))
		else $error("read length wrong");
	hit_nodisk_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(acc && unit_ok && hit) |=> done_o && done_hit_o && qcnt == $past(qcnt) - {3'h0, $past(go_req)})
		else $error("cache hit queued or not completed");
	wr_at_disc_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(acc && unit_ok && req_write_i && !cache_q) |=> !done_o)
		else $error("write completed before disc");
	struct_rct_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_q == DSC_ST_STB && dsk_done_i) |=> st_q == ($past(rct_q) ? DSC_ST_RCT : DSC_ST_IDLE)
		##0 (rct_q ? dsk_start_o && dsk_op_o == DSC_OP_RCTCLR : 1'b1))
		else $error("structure write tail wrong");
	fmt_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_q == DSC_ST_HDR && dsk_done_i) |=> dsk_start_o && dsk_op_o == DSC_OP_PATTERN)
		else $error("pattern pass not started");
	stat_period_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(go_req && acc_q == `DSC_STAT_PERIOD - 10'h001) |=> stw_q && acc_q == 10'h000)
		else $error("statistics write not requested");
	absent_unit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(acc && !unit_ok) |=> done_o && done_err_o)
		else $error("absent unit request not refused");
endmodule

// ===== sim/dsc_disc_model.sv
// Disc side responder that finishes each started op after a set latency
module dsc_disc_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       start_i,
	input  wire logic [7:0] lat_i,
	output logic            done_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_q;
	// One op open at a time; done pulses only while an op is open, never unprompted
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q  <= 8'h00;
			done_o <= 1'b0;
		end else begin
			done_o <= (cnt_q == 8'h01);
			if (start_i)
				cnt_q <= lat_i;
			else if (cnt_q != 8'h00)
				cnt_q <= cnt_q - 8'h01;
		end
	end
endmodule

// ===== sim/dsc_sched_tb.sv
// Self-checking bench of the disc request scheduler
`include "dsc_consts.svh"
module dsc_sched_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import dsc_pkg::*;
	logic        clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
	logic        req_valid_i = 1'b0, req_write_i = 1'b0;
	logic [1:0]  req_unit_i = 2'h0, info_unit_i = 2'h0, dsk_unit_o;
	logic [7:0]  addr_i = 8'h00, req_len_i = 8'h01, lat = 8'h03, dsk_len_o;
	logic [15:0] req_cyl_i = 16'h0000, dsk_cyl_o;
	logic [31:0] wdata_i = 32'h0, req_lba_i = 32'h0, rdata_o, dsk_lba_o, info_serial_o;
	logic [39:0] info_media_o;
	logic [3:0]  units_o;
	logic        req_ready_o, done_o, done_hit_o, done_err_o, dsk_start_o, dsk_done_i;
	dsc_op_t     dsk_op_o;
	dsc_panel_t  panel_o;
	dsc_op_t     ops[$];
	logic [15:0] cyls[$];
	logic [7:0]  lens[$];
	int          bad_count = 0, cmp_count = 0, dn = 0;

	dsc_sched dut (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .req_valid_i,
		.req_ready_o, .req_unit_i, .req_write_i, .req_cyl_i, .req_lba_i, .req_len_i, .done_o,
		.done_hit_o, .done_err_o, .dsk_start_o, .dsk_op_o, .dsk_unit_o, .dsk_cyl_o, .dsk_lba_o,
		.dsk_len_o, .dsk_done_i, .info_unit_i, .info_media_o, .info_serial_o, .units_o, .panel_o);
	dsc_disc_model disc (.clk_i, .rst_i, .start_i(dsk_start_o), .lat_i(lat), .done_o(dsk_done_i));

	// Clock
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	// Log disc op starts and count host completion pulses; ops land in order of issue
	always @(posedge clk_i) begin
		if (dsk_start_o === 1'b1) begin
			ops.push_back(dsk_op_o);
			cyls.push_back(dsk_cyl_o);
			lens.push_back(dsk_len_o);
		end
		if (done_o === 1'b1)
			dn++;
	end
	// Compare and count
	task automatic chk(input string nm, input logic [39:0] g, input logic [39:0] e);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %0h got %0h", nm, e, g);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic to;
		bad_count++;
		$display("MISMATCH wait exp done got timeout");
		tally_and_finish();
	endtask
	// Register bus: one-cycle strobes, read data in the next cycle only
	task automatic bw(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic br(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		br(a, d);
		chk("reg", d, e);
	endtask
	// Host request held until accepted; returns at the accepting edge
	task automatic rq(input logic [1:0] u, input logic w, input logic [15:0] c,
			input logic [31:0] l, input logic [7:0] n);
		int i;
		@(posedge clk_i);
		req_valid_i <= 1'b1;
		req_unit_i  <= u;
		req_write_i <= w;
		req_cyl_i   <= c;
		req_lba_i   <= l;
		req_len_i   <= n;
		@(negedge clk_i);
		for (i = 0; i < 300 && req_ready_o !== 1'b1; i++) @(negedge clk_i);
		if (i >= 300) to();
		@(posedge clk_i);
		req_valid_i <= 1'b0;
	endtask
	// Bounded waits: completion pulse, op count, sequencer idle
	task automatic wd(output int n);
		n = 0;
		#1;
		while (done_o !== 1'b1) begin
			@(posedge clk_i);
			#1 n++;
			if (n > 300) to();
		end
	endtask
	task automatic wo(input int n, input int d);
		int i;
		for (i = 0; i < 400 && (ops.size() < n || dn < d); i++) @(posedge clk_i);
		if (i >= 400) to();
	endtask
	task automatic wi;
		int i;
		logic [31:0] d;
		for (i = 0; i < 100; i++) begin
			br(`DSC_OFF_STRUCT, d);
			if (d === 32'h0) break;
		end
		if (i >= 100) to();
	endtask
	task automatic clr;
		#1;
		ops.delete();
		cyls.delete();
		lens.delete();
	endtask
	// Reset values, every strategy and defined panel code, unmapped read
	task automatic t_reset;
		int k;
		rc(`DSC_OFF_CTRL, 32'h4);
		rc(`DSC_OFF_FAIR, 32'h19);
		rc(`DSC_OFF_QDEPTH, 32'h8);
		rc(8'h3c, 32'h0);
		for (k = 0; k < 4; k++) begin
			bw(`DSC_OFF_CTRL, {27'h0, 2'(k % 3), 1'b1, 2'(k)});
			rc(`DSC_OFF_CTRL, {27'h0, 2'(k % 3), 1'b1, 2'(k)});
			chk("panel", panel_o, 40'(k % 3));
		end
	endtask
	// No unit defined: request refused, nothing presented
	task automatic t_absent;
		int n;
		bw(`DSC_OFF_CTRL, 32'h4);
		rq(2'h0, 1'b0, 16'h10, 32'h0, 8'h01);
		wd(n);
		chk("err", done_err_o, 1'b1);
		chk("units", units_o, 4'h0);
	endtask
	// Unit 0 defined with media and serial; unit 1 keeps defaults
	task automatic t_units;
		bw(`DSC_OFF_USEL, 32'h0);
		bw(`DSC_OFF_USIZE, 32'h3e8);
		bw(`DSC_OFF_UMEDIA_LO, 32'h44434241);
		bw(`DSC_OFF_UMEDIA_HI, 32'h45);
		bw(`DSC_OFF_USERIAL, 32'h12345678);
		repeat (2) @(posedge clk_i);
		chk("units", units_o, 4'h1);
		rc(`DSC_OFF_STATUS, 32'h10);
		chk("media", info_media_o, 40'h4544434241);
		chk("serial", info_serial_o, 32'h12345678);
		info_unit_i <= 2'h1;
		repeat (2) @(posedge clk_i);
		chk("serial dflt", info_serial_o, 32'h0);
	endtask
	// Lookahead fetch, hit without disc, long read, cache off
	task automatic t_cache;
		int n;
		bw(`DSC_OFF_LOOK, 32'h4);
		clr();
		rq(2'h0, 1'b0, 16'h10, 32'h40, 8'h01);
		wd(n);
		chk("look len", lens[0], 8'h04);
		rq(2'h0, 1'b0, 16'h10, 32'h43, 8'h01);
		wd(n);
		chk("hit", done_hit_o, 1'b1);
		chk("no disc", 40'(lens.size()), 40'h1);
		rc(`DSC_OFF_STAT_HIT, 32'h1);
		rq(2'h0, 1'b0, 16'h10, 32'h80, 8'h08);
		wd(n);
		chk("long len", lens[1], 8'h08);
		bw(`DSC_OFF_CTRL, 32'h0);
		rq(2'h0, 1'b0, 16'h10, 32'h84, 8'h01);
		wd(n);
		chk("off hit", done_hit_o, 1'b0);
		chk("off len", lens[2], 8'h01);
	endtask
	// Write completion at cache or at disc
	task automatic t_wconf;
		int n;
		bw(`DSC_OFF_CTRL, 32'h4);
		bw(`DSC_OFF_UWCONF, 32'h1);
		clr();
		rq(2'h0, 1'b1, 16'h20, 32'h100, 8'h01);
		wd(n);
		chk("cache ack", n <= 1, 1'b1);
		wo(1, 0);
		bw(`DSC_OFF_UWCONF, 32'h2);
		rq(2'h0, 1'b1, 16'h20, 32'h101, 8'h01);
		wd(n);
		chk("disc ack", n > 2, 1'b1);
		bw(`DSC_OFF_CTRL, 32'h0);
		bw(`DSC_OFF_UWCONF, 32'h1);
		rq(2'h0, 1'b1, 16'h20, 32'h102, 8'h01);
		wd(n);
		chk("off ack", n > 2, 1'b1);
	endtask
	// Structure write, header update, format
	task automatic t_seq;
		int i;
		dsc_op_t ex[10] = '{DSC_OP_STRUCT, DSC_OP_STRUCT, DSC_OP_RCTCLR, DSC_OP_STRUCT,
			DSC_OP_STRUCT, DSC_OP_HDRFMT, DSC_OP_PATTERN, DSC_OP_STRUCT, DSC_OP_STRUCT,
			DSC_OP_RCTCLR};
		clr();
		bw(`DSC_OFF_STRUCT, 32'h2);
		wi();
		bw(`DSC_OFF_STRUCT, 32'h3);
		wi();
		bw(`DSC_OFF_STRUCT, 32'h1);
		wi();
		chk("blocks", lens[0] + lens[1], 8'h06);
		chk("ops", 40'(ops.size()), 40'ha);
		for (i = 0; i < 10; i++) chk("op", ops[i], ex[i]);
	endtask
	// Order of service with one request open and three queued behind it
	task automatic t_ord(input logic [1:0] s, input logic [7:0] f, input logic [63:0] e);
		int i;
		int d0;
		bw(`DSC_OFF_CTRL, {30'h0, s});
		bw(`DSC_OFF_FAIR, {24'h0, f});
		lat <= 8'h1e;
		clr();
		d0 = dn;
		rq(2'h0, 1'b0, 16'h64, 32'h200, 8'h01);
		wo(1, 0);
		rq(2'h0, 1'b0, 16'h32, 32'h300, 8'h01);
		rq(2'h0, 1'b0, 16'h12c, 32'h400, 8'h01);
		rq(2'h0, 1'b0, 16'hc8, 32'h500, 8'h01);
		wo(4, d0 + 4);
		for (i = 0; i < 4; i++) chk("cyl", cyls[i], e[63-16*i -: 16]);
	endtask
	// Statistics op lands exactly every 1000 issued requests
	task automatic t_stats;
		int j, n, f;
		f = -1;
		lat <= 8'h02;
		bw(`DSC_OFF_CTRL, 32'h0);
		for (j = 0; j < 2100; j++) begin
			clr();
			rq(2'h0, 1'b0, 16'h5, 32'h0, 8'h01);
			wd(n);
			if (ops.size() > 1) begin
				if (f >= 0) break;
				f = j;
			end
		end
		chk("stats gap", 40'(j - f), 40'h3e8);
		chk("stats op", ops[0], DSC_OP_STATS);
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_absent();
		t_units();
		t_cache();
		t_wconf();
		t_seq();
		t_ord(2'h3, 8'h19, {16'h64, 16'hc8, 16'h12c, 16'h32});
		t_ord(2'h1, 8'h01, {16'h64, 16'h32, 16'h12c, 16'hc8});
		t_ord(2'h0, 8'h00, {16'h64, 16'h32, 16'h12c, 16'hc8});
		t_stats();
		tally_and_finish();
	end
endmodule
